// [core/cap_mem.v]
// Small memory holding the capability words of each stream record.
// Assumes one write and one read port on mclk; read data is registered.
`timescale 1ns/100ps
module cap_mem #(
    parameter DW = 32,
    parameter AW = 6
) (
    input  wire          mclk,   // Clock
    input  wire          reset,  // Async reset, active high
    input  wire          we,     // Write enable
    input  wire [AW-1:0] waddr,  // Write address
    input  wire [DW-1:0] wdata,  // Write data
    input  wire [AW-1:0] raddr,  // Read address
    output reg  [DW-1:0] rdata   // Read data, one cycle after raddr
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ------------------------------------------------------------------
    // Storage: array left unreset, only the read register is cleared
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata <= {DW{1'b0}};
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule // cap_mem

// [core/pcm_ctl_regs.vh]
// Constants of the PCM stream control master: register offsets, request
// and status codes, field positions, stream states and local error codes.
// Assumes it is included by bare name into the design files.
`ifndef PCM_CTL_REGS_VH
`define PCM_CTL_REGS_VH

// ----------------------------------------------------------------------
// Software register offsets (byte addresses, 8-bit address bus)
// ----------------------------------------------------------------------
`define OFF_CMD     8'h00
`define OFF_BUF     8'h04
`define OFF_PER     8'h08
`define OFF_FEAT    8'h0C
`define OFF_CFMT    8'h10
`define OFF_COUNT   8'h14
`define OFF_STATUS  8'h18
`define OFF_STATE   8'h1C

// ----------------------------------------------------------------------
// Request codes: consecutive from the base, op = code - base
// ----------------------------------------------------------------------
`define CODE_BASE   32'h00000100
`define OP_INFO     3'h0
`define OP_SET      3'h1
`define OP_PREP     3'h2
`define OP_REL      3'h3
`define OP_START    3'h4
`define OP_STOP     3'h5

// ----------------------------------------------------------------------
// Response status codes (low 16 bits kept)
// ----------------------------------------------------------------------
`define ST_OK       16'h8000
`define ST_BAD_MSG  16'h8001
`define ST_NOT_SUPP 16'h8002
`define ST_IO_ERR   16'h8003

// ----------------------------------------------------------------------
// Feature bits, format and rate enumeration sizes, record layout
// ----------------------------------------------------------------------
`define F_SHM_HOST  0
`define F_SHM_GUEST 1
`define F_POLL      2
`define F_EVT_PER   3
`define F_EVT_XRUN  4
`define FEAT_MASK   32'h0000001F
`define FMT_COUNT   6'h19
`define RATE_COUNT  4'hE
`define DIR_OUT     8'h00
`define DIR_IN      8'h01
`define INFO_SIZE   32'h00000020
`define W_FEAT      3'h1
`define W_FMT_LO    3'h2
`define W_FMT_HI    3'h3
`define W_RATE_LO   3'h4
`define W_CHAN      3'h6

// ----------------------------------------------------------------------
// Per-stream lifecycle states as seen by the controller
// ----------------------------------------------------------------------
`define SS_IDLE     3'h0
`define SS_PARAMS   3'h1
`define SS_PREPARED 3'h2
`define SS_RUNNING  3'h3
`define SS_STOPPED  3'h4
`define SS_RELEASED 3'h5

// ----------------------------------------------------------------------
// Local error codes shown in the status register
// ----------------------------------------------------------------------
`define ERR_NONE    4'h0
`define ERR_OP      4'h1
`define ERR_STREAM  4'h2
`define ERR_SEQ     4'h3
`define ERR_PARAM   4'h4
`define ERR_DEV     4'h5
`define ERR_NOCAP   4'h6

`endif

// [core/pcm_stream_control.v]
// Driver-side master for the PCM control messages of a sound device.
// Assumes a word link: requests go out as le32 words with valid/ready,
// responses come back as le32 words with valid and last, never stalled.
//
// Function
// - Each request starts with code word, then stream id below stream count
// - Request codes run from 0x0100: info, set, prepare, release, start, stop
// - After set parameters only set parameters or prepare are legal
// - Prepare allocates; then set, prepare, start or release are legal
// - Output streams may be pre-buffered between prepare and start
// - Start runs and unmutes; while running only stop is legal
// - Stop mutes and halts; then start or release are legal
// - Release frees resources; then set parameters or prepare are legal
// - Feature bits: host shm, guest shm, polling, shm periods, xruns
// - Format bit indices follow the format enumeration from zero
// - Rate bit indices run 5512 Hz at zero to 384000 Hz at thirteen
// - Set request: header, buffer, period, features, channels, format, rate, zero pad
// - Never select a shared memory feature bit; data uses queues
// - Period size divides buffer size exactly
// - Select only defined values present in the stream capabilities
// - Channel count lies within the advertised minimum and maximum
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "pcm_ctl_regs.vh"
module pcm_stream_control #(
    parameter SIDW = 3
) (
    input  wire        mclk,      // Clock, 200 MHz
    input  wire        reset,     // Async reset, active high
    input  wire [7:0]  sw_addr,   // Register byte address
    input  wire [31:0] sw_wdata,  // Register write data
    input  wire        sw_wr,     // Write strobe
    input  wire        sw_rd,     // Read strobe
    output reg  [31:0] sw_rdata,  // Read data, cycle after sw_rd
    output reg         req_valid, // Request word valid
    output reg  [31:0] req_data,  // Request word, le32 value
    output reg         req_last,  // Last word of request
    input  wire        req_ready, // Device takes request word
    input  wire        rsp_valid, // Response word valid
    input  wire [31:0] rsp_data,  // Response word, le32 value
    input  wire        rsp_last   // Last word of response
);

    localparam NSTREAMS = 1 << SIDW;
    localparam AW       = SIDW + 3;
    localparam [7:0] NS8 = NSTREAMS;
    localparam [2:0] S_IDLE = 3'h0, S_DIV = 3'h1, S_CAP = 3'h2,
                     S_SEND = 3'h3, S_RSP = 3'h4;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [2:0]  state_reg;
    reg [31:0] buf_reg, per_reg, feat_reg;
    reg [7:0]  chan_reg, fmt_reg, rate_reg, cnt_reg;
    reg [2:0]  op_reg;
    reg [7:0]  sid_reg;
    reg [3:0]  err_reg;
    reg [15:0] res_reg;
    reg        caps_valid_reg;
    reg [3*NSTREAMS-1:0] st_reg;
    reg [32:0] rem_reg;
    reg [5:0]  div_i_reg;
    reg [2:0]  cap_step_reg;
    reg [2:0]  widx_reg;
    reg [11:0] rcnt_reg;

    // Transition table of the stream lifecycle
    function legal;
        input [2:0] op;
        input [2:0] cur;
        begin
            case (op)
                `OP_SET:   legal = (cur == `SS_IDLE) || (cur == `SS_PARAMS) ||
                                   (cur == `SS_PREPARED) || (cur == `SS_RELEASED);
                `OP_PREP:  legal = (cur == `SS_PARAMS) || (cur == `SS_PREPARED) ||
                                   (cur == `SS_RELEASED);
                `OP_START: legal = (cur == `SS_PREPARED) || (cur == `SS_STOPPED);
                `OP_STOP:  legal = (cur == `SS_RUNNING);
                `OP_REL:   legal = (cur == `SS_PREPARED) || (cur == `SS_STOPPED);
                default:   legal = 1'b0;
            endcase
        end
    endfunction

    // State a stream enters once the device accepts the command
    function [2:0] next_st;
        input [2:0] op;
        begin
            case (op)
                `OP_SET:   next_st = `SS_PARAMS;
                `OP_PREP:  next_st = `SS_PREPARED;
                `OP_START: next_st = `SS_RUNNING;
                `OP_STOP:  next_st = `SS_STOPPED;
                `OP_REL:   next_st = `SS_RELEASED;
                default:   next_st = `SS_IDLE;
            endcase
        end
    endfunction

    // Request word by index; bytes of the last set word are little-endian
    function [31:0] req_word;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    req_word = `CODE_BASE + {29'h0, op_reg};
                3'h1:    req_word = (op_reg == `OP_INFO) ? 32'h0 : {24'h0, sid_reg};
                3'h2:    req_word = (op_reg == `OP_INFO) ? {24'h0, cnt_reg} : buf_reg;
                3'h3:    req_word = (op_reg == `OP_INFO) ? `INFO_SIZE : per_reg;
                3'h4:    req_word = feat_reg;
                3'h5:    req_word = {8'h00, rate_reg, fmt_reg, chan_reg};
                default: req_word = 32'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------------
    wire [2:0]  nwords = (op_reg == `OP_INFO) ? 3'h4 :
                         (op_reg == `OP_SET) ? 3'h6 : 3'h2;
    wire [32:0] div_t = {rem_reg[31:0], buf_reg[div_i_reg[4:0]]};
    wire [32:0] div_r = (div_t >= {1'b0, per_reg}) ? div_t - {1'b0, per_reg} : div_t;
    wire        ok_rsp = (res_reg == `ST_OK);
    wire [11:0] rcm1 = rcnt_reg - 12'h001;
    wire [7:0]  w_sid = sw_wdata[15:8];
    wire [2:0]  w_op = sw_wdata[2:0];
    // Shared memory bits are refused outright; other quick checks too
    wire        quick_bad = (per_reg == 32'h0) ||
                            ((feat_reg & ~`FEAT_MASK) != 32'h0) ||
                            feat_reg[`F_SHM_HOST] ||
                            feat_reg[`F_SHM_GUEST] ||
                            (fmt_reg[7:6] != 2'h0) ||
                            (fmt_reg[5:0] >= `FMT_COUNT) ||
                            (rate_reg[7:4] != 4'h0) ||
                            (rate_reg[3:0] >= `RATE_COUNT);

    // Capability word fetched at each check step
    reg [2:0] cap_word;
    always @* begin
        case (cap_step_reg)
            3'h0:    cap_word = `W_FEAT;
            3'h1:    cap_word = fmt_reg[5] ? `W_FMT_HI : `W_FMT_LO;
            3'h2:    cap_word = `W_RATE_LO;
            default: cap_word = `W_CHAN;
        endcase
    end

    // Info records are stored as they stream past; words 1 to 6 kept
    wire          mem_we = (state_reg == S_RSP) && rsp_valid && (rcnt_reg != 12'h0) &&
                           (op_reg == `OP_INFO) && ok_rsp &&
                           (rcm1[2:0] >= `W_FEAT) && (rcm1[2:0] <= `W_CHAN) &&
                           (rcm1[11:AW] == {(12-AW){1'b0}});
    wire [31:0]   cap_rdata;

    cap_mem #(.DW(32), .AW(AW)) u_cap (
        .mclk  (mclk),
        .reset (reset),
        .we    (mem_we),
        .waddr (rcm1[AW-1:0]),
        .wdata (rsp_data),
        .raddr ({sid_reg[SIDW-1:0], cap_word}),
        .rdata (cap_rdata)
    );

    // ------------------------------------------------------------------
    // Software parameter registers; frozen while a command is in flight
    // ------------------------------------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            buf_reg  <= 32'h0;
            per_reg  <= 32'h0;
            feat_reg <= 32'h0;
            chan_reg <= 8'h0;
            fmt_reg  <= 8'h0;
            rate_reg <= 8'h0;
            cnt_reg  <= 8'h0;
        end else if (sw_wr && (state_reg == S_IDLE)) begin
            case (sw_addr)
                `OFF_BUF:   buf_reg  <= sw_wdata;
                `OFF_PER:   per_reg  <= sw_wdata;
                `OFF_FEAT:  feat_reg <= sw_wdata;
                `OFF_CFMT: begin
                    chan_reg <= sw_wdata[7:0];
                    fmt_reg  <= sw_wdata[15:8];
                    rate_reg <= sw_wdata[23:16];
                end
                `OFF_COUNT: cnt_reg  <= sw_wdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer: checks, request transmit, response parse
    // ------------------------------------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg      <= S_IDLE;
            op_reg         <= `OP_INFO;
            sid_reg        <= 8'h0;
            err_reg        <= `ERR_NONE;
            res_reg        <= 16'h0;
            caps_valid_reg <= 1'b0;
            st_reg         <= {(3*NSTREAMS){1'b0}};
            rem_reg        <= 33'h0;
            div_i_reg      <= 6'h0;
            cap_step_reg   <= 3'h0;
            widx_reg       <= 3'h0;
            rcnt_reg       <= 12'h0;
            req_valid      <= 1'b0;
            req_data       <= 32'h0;
            req_last       <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (sw_wr && (sw_addr == `OFF_CMD)) begin
                        op_reg       <= w_op;
                        sid_reg      <= w_sid;
                        err_reg      <= `ERR_NONE;
                        rem_reg      <= 33'h0;
                        div_i_reg    <= 6'h1F;
                        cap_step_reg <= 3'h0;
                        widx_reg     <= 3'h0;
                        if (w_op > `OP_STOP) begin
                            err_reg <= `ERR_OP;
                        end else if (w_op == `OP_INFO) begin
                            if ((cnt_reg == 8'h0) || (cnt_reg > NS8)) begin
                                err_reg <= `ERR_STREAM;
                            end else begin
                                caps_valid_reg <= 1'b0;
                                state_reg      <= S_SEND;
                            end
                        end else if ((w_sid >= cnt_reg) || (w_sid >= NS8)) begin
                            err_reg <= `ERR_STREAM;
                        end else if (!legal(w_op, st_reg[w_sid[SIDW-1:0]*3 +: 3])) begin
                            err_reg <= `ERR_SEQ;
                        end else if (w_op == `OP_SET) begin
                            if (!caps_valid_reg) begin
                                err_reg <= `ERR_NOCAP;
                            end else begin
                                state_reg <= S_DIV;
                            end
                        end else begin
                            state_reg <= S_SEND;
                        end
                    end
                end
                // Restoring remainder of buffer by period, one bit a cycle
                S_DIV: begin
                    rem_reg   <= div_r;
                    div_i_reg <= div_i_reg - 6'h01;
                    if (quick_bad) begin
                        err_reg   <= `ERR_PARAM;
                        state_reg <= S_IDLE;
                    end else if (div_i_reg == 6'h0) begin
                        if (div_r != 33'h0) begin
                            err_reg   <= `ERR_PARAM;
                            state_reg <= S_IDLE;
                        end else begin
                            state_reg <= S_CAP;
                        end
                    end
                end
                // Read data lags the step by one: step k checks word k-1
                S_CAP: begin
                    cap_step_reg <= cap_step_reg + 3'h1;
                    if (((cap_step_reg == 3'h1) && ((feat_reg & ~cap_rdata) != 32'h0)) ||
                        ((cap_step_reg == 3'h2) && !cap_rdata[fmt_reg[4:0]]) ||
                        ((cap_step_reg == 3'h3) && !cap_rdata[rate_reg[3:0]]) ||
                        ((cap_step_reg == 3'h4) && ((chan_reg < cap_rdata[15:8]) ||
                                                    (chan_reg > cap_rdata[23:16])))) begin
                        err_reg   <= `ERR_PARAM;
                        state_reg <= S_IDLE;
                    end else if (cap_step_reg == 3'h4) begin
                        state_reg <= S_SEND;
                    end
                end
                // Words leave back to back while the device is ready
                S_SEND: begin
                    if (!req_valid) begin
                        req_valid <= 1'b1;
                        req_data  <= req_word(3'h0);
                        req_last  <= 1'b0;
                        widx_reg  <= 3'h1;
                    end else if (req_ready) begin
                        if (req_last) begin
                            req_valid <= 1'b0;
                            req_last  <= 1'b0;
                            rcnt_reg  <= 12'h0;
                            state_reg <= S_RSP;
                        end else begin
                            req_data <= req_word(widx_reg);
                            req_last <= (widx_reg == nwords - 3'h1);
                            widx_reg <= widx_reg + 3'h1;
                        end
                    end
                end
                // First word is status, info records follow
                S_RSP: begin
                    if (rsp_valid) begin
                        rcnt_reg <= rcnt_reg + 12'h001;
                        if (rcnt_reg == 12'h0) begin
                            res_reg <= rsp_data[15:0];
                        end
                        if (rsp_last) begin
                            state_reg <= S_IDLE;
                            if ((rcnt_reg == 12'h0) ? (rsp_data[15:0] != `ST_OK) : !ok_rsp) begin
                                err_reg <= `ERR_DEV;
                            end else if (op_reg == `OP_INFO) begin
                                caps_valid_reg <= 1'b1;
                            end else begin
                                st_reg[sid_reg[SIDW-1:0]*3 +: 3] <= next_st(op_reg);
                            end
                        end
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read port: data stands in the cycle after the strobe only
    // ------------------------------------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            sw_rdata <= 32'h0;
        end else if (sw_rd) begin
            case (sw_addr)
                `OFF_BUF:    sw_rdata <= buf_reg;
                `OFF_PER:    sw_rdata <= per_reg;
                `OFF_FEAT:   sw_rdata <= feat_reg;
                `OFF_CFMT:   sw_rdata <= {8'h00, rate_reg, fmt_reg, chan_reg};
                `OFF_COUNT:  sw_rdata <= {24'h0, cnt_reg};
                `OFF_STATUS: sw_rdata <= {res_reg, 8'h00, err_reg, 2'b00,
                                          caps_valid_reg, (state_reg != S_IDLE)};
                `OFF_STATE:  sw_rdata <= {{(32-3*NSTREAMS){1'b0}}, st_reg};
                default:     sw_rdata <= 32'h0;
            endcase
        end else begin
            sw_rdata <= 32'h0;
        end
    end

endmodule // pcm_stream_control

// [sim/pcm_ctl_chk.sv]
// Checker for the request words of the PCM control master.
// Assumes it sees the top ports only; bound at the foot.
`timescale 1ns/100ps
module pcm_ctl_chk #(parameter SIDW = 3) (
    input wire        mclk,      // Clock
    input wire        reset,     // Reset
    input wire        req_valid, // Valid
    input wire [31:0] req_data,  // Word
    input wire        req_last,  // Last
    input wire        req_ready, // Taken
    input wire        rsp_valid, // Answer
    input wire        rsp_last   // End
);
    reg [2:0]  widx, op;
    reg [31:0] bq, pq;
    wire       tk = req_valid && req_ready;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Word index and saved sizes, so later words can be judged
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            {widx, op, bq, pq} <= 70'h0;
        end else if (tk) begin
            widx <= req_last ? 3'h0 : widx + 3'h1;
            if (widx == 0) op <= req_data[2:0];
            if (widx == 2) bq <= req_data;
            if (widx == 3) pq <= req_data;
        end
    end
    property p_hold; req_valid && !req_ready |=> req_valid && $stable({req_data, req_last}); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    property p_code; req_valid && widx == 0 |-> req_data >= 32'h100 && req_data <= 32'h105; endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_sid; req_valid && widx == 1 |-> req_data < (32'h1 << SIDW); endproperty
    a_sid: assert property (p_sid) else $error("bad stream");
    property p_short; req_valid && widx == 1 && op >= 3'h2 |-> req_last; endproperty
    a_short: assert property (p_short) else $error("long request");
    property p_info; req_valid && widx == 3 && op == 0 |-> req_last && req_data == 32'h20; endproperty
    a_info: assert property (p_info) else $error("bad query");
    property p_feat; req_valid && widx == 4 |-> req_data[1:0] == 0 && req_data[31:5] == 0; endproperty
    a_feat: assert property (p_feat) else $error("bad features");
    property p_div; req_valid && widx == 4 |-> pq != 0 && bq % pq == 0; endproperty
    a_div: assert property (p_div) else $error("bad period");
    property p_pad; req_valid && widx == 5 |-> req_last && req_data[31:24] == 0; endproperty
    a_pad: assert property (p_pad) else $error("bad pad");
    c_set: cover property (tk && req_last && op == 1);
    c_stall: cover property (req_valid && !req_ready);
    c_end: cover property (rsp_valid && rsp_last);
endmodule // pcm_ctl_chk
bind pcm_stream_control pcm_ctl_chk #(.SIDW(SIDW)) i_chk (.mclk(mclk), .reset(reset),
    .req_valid(req_valid), .req_data(req_data), .req_last(req_last),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_last(rsp_last));

// [sim/snd_dev_model.sv]
// Behavioural sound device answering PCM control requests.
// Assumes the master's word link; slow stalls every other cycle.
`timescale 1ns/100ps
module snd_dev_model (
    input wire        mclk,      // Clock
    input wire        reset,     // Reset
    input wire        slow,      // Stall mode
    input wire [15:0] status,    // Answer status
    input wire        req_valid, // Valid
    input wire [31:0] req_data,  // Word
    input wire        req_last,  // Last
    output reg        req_ready, // Taken
    output reg        rsp_valid, // Answer
    output reg [31:0] rsp_data,  // Answer word
    output reg        rsp_last   // End
);
    reg [2:0]  wi;
    reg [8:0]  left, k;
    reg [31:0] code, n;
    wire [2:0] ws = k[2:0] - 3'h1;
    // Take a request, then answer status, plus one record per queried stream for info
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            {req_ready, rsp_valid, rsp_last, wi, left, k, code, n, rsp_data} <= '0;
        end else begin
            req_ready <= slow ? ~req_ready : 1'b1;
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
            rsp_data <= ~rsp_data; // Idle word never repeats the last one
            if (req_valid && req_ready) begin
                wi <= req_last ? 3'h0 : wi + 3'h1;
                if (wi == 0) code <= req_data;
                if (wi == 2) n <= req_data;
                if (req_last) left <= (code == 32'h100 ? {n[5:0], 3'h0} : 9'h0) + 9'h1;
                k <= 9'h0;
            end else if (left != 0) begin
                rsp_valid <= 1'b1;
                rsp_last <= left == 1;
                left <= left - 9'h1;
                k <= k + 9'h1;
                if (k == 0) rsp_data <= {16'h0, status};
                else case (ws)
                    3'h1: rsp_data <= 32'h1C; // polling and both events
                    3'h2: rsp_data <= 32'h20; // one format, index 5
                    3'h4: rsp_data <= 32'h80; // 48000 Hz only
                    3'h6: rsp_data <= 32'h00020100; // output, 1 to 2 channels
                    default: rsp_data <= 32'h0;
                endcase
            end
        end
    end
endmodule // snd_dev_model

// [sim/test_pcm_stream_control.sv]
// Self-checking bench: master, device model, checker by bind.
// Assumes the design header is on the include path.
`timescale 1ns/100ps
`include "pcm_ctl_regs.vh"
module test_pcm_stream_control;
    reg         mclk = 0, reset = 1, sw_wr = 0, sw_rd = 0, slow = 0;
    reg  [7:0]  sw_addr = 0;
    reg  [31:0] sw_wdata = 0, rv;
    reg  [15:0] dst = 16'h8000;
    reg  [11:0] r;
    wire [31:0] sw_rdata, req_data, rsp_data;
    wire        req_valid, req_last, req_ready, rsp_valid, rsp_last;
    integer     bad_count = 0, total_checks = 0, cyc = 0, i;
    // Rows: op, expected error, expected state of stream 0
    localparam [155:0] ROWS = {12'h160, 12'h000, 12'h230, 12'h101, 12'h431, 12'h202, 12'h403,
                               12'h133, 12'h504, 12'h234, 12'h305, 12'h202, 12'h612};
    pcm_stream_control #(.SIDW(3)) i_dut (.mclk(mclk), .reset(reset), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .req_valid(req_valid), .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last));
    snd_dev_model i_dev (.mclk(mclk), .reset(reset), .slow(slow), .status(dst),
        .req_valid(req_valid), .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last));
    always #2.5 mclk = ~mclk;
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge mclk);
        {sw_wr, sw_addr, sw_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge mclk);
        {sw_rd, sw_addr} <= {1'b1, a};
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 rv = sw_rdata;
    endtask
    // Issue a command and poll until the busy flag drops, bounded
    task cmd(input [3:0] op, input [7:0] id);
        integer j;
        wr(`OFF_CMD, {16'h0, id, 5'h0, op[2:0]});
        rv = 32'h1;
        for (j = 0; j < 200 && rv[0] !== 1'b0; j = j + 1) rd(`OFF_STATUS);
        chk("busy", rv[0], 0);
    endtask
    task stop_test;
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            stop_test;
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd(`OFF_STATE);
        chk("state", rv, 0);
        rd(8'h24);
        chk("unmapped", rv, 0);
        wr(`OFF_COUNT, 2);
        wr(`OFF_BUF, 32'h40);
        wr(`OFF_PER, 32'h10);
        wr(`OFF_FEAT, 32'h4);
        slow <= 1'b1;
        for (i = 0; i < 13; i = i + 1) begin
            r = ROWS[(12 - i) * 12 +: 12];
            wr(`OFF_CFMT, 32'h070502);
            cmd(r[11:8], 0);
            chk("error", rv[7:4], r[7:4]);
            rd(`OFF_STATE);
            chk("stream0", rv[2:0], r[2:0]);
        end
        slow <= 1'b0;
        cmd(1, 2);
        chk("id range", rv[7:4], 2);
        // Bad period, shared memory, channels, format; last pass is clean
        for (i = 0; i < 5; i = i + 1) begin
            wr(`OFF_PER, i == 0 ? 32'h30 : 32'h10);
            wr(`OFF_FEAT, i == 1 ? 32'h1 : 32'h4);
            wr(`OFF_CFMT, i == 2 ? 32'h070503 : i == 3 ? 32'h070602 : 32'h070502);
            cmd(1, 1);
            chk("params", rv[7:4], i == 4 ? 0 : 4);
        end
        dst <= 16'h8001;
        cmd(2, 1);
        chk("dev status", rv, 32'h80010052);
        rd(`OFF_STATE);
        chk("stream1", rv[5:3], 1);
        stop_test;
    end
endmodule // test_pcm_stream_control
